// ### verilog/nvm_prog_map.svh
/*
 * Constants for the serial programming command interpreter: command codes,
 * address regions, timing figures and the cycle counts derived from them.
 * Assumes the interpreter runs from a 50 ns system clock.
 */
`ifndef NVM_PROG_MAP_SVH
`define NVM_PROG_MAP_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define NVM_CMD_LOAD_ADDR     8'h80
`define NVM_CMD_BULK_ERASE    8'h18
`define NVM_CMD_ROW_ERASE     8'hF0
`define NVM_CMD_LOAD_DATA     8'h00
`define NVM_CMD_LOAD_DATA_INC 8'h02
`define NVM_CMD_READ_DATA     8'hFC
`define NVM_CMD_READ_DATA_INC 8'hFE
`define NVM_CMD_INC_ADDR      8'hF8
`define NVM_CMD_BEGIN_INT     8'hE0
`define NVM_CMD_BEGIN_EXT     8'hC0
`define NVM_CMD_END_EXT       8'h82
`define NVM_CMD_INC_BIT       1

// ----------------------------------------------------------------------
// Payload framing and address regions
// ----------------------------------------------------------------------
`define NVM_PAYLOAD_BITS      24
`define NVM_FLASH_LAST        16'h7FFF
`define NVM_ID_FIRST          16'h8000
`define NVM_ID_LAST           16'h8004
`define NVM_CFG_FIRST         16'h8007
`define NVM_CFG_LAST          16'h800B
`define NVM_IDCFG_LAST        16'h80FD
`define NVM_FLASHONLY_LAST    16'h80FF
`define NVM_NOP_LAST          16'hE7FF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define NVM_CLOCK_PERIOD_NS   50
`define NVM_INTERNAL_WRITE_NS 5000
`define NVM_BULK_ERASE_NS     10000
`define NVM_ROW_ERASE_NS      5000
`define NVM_INTERNAL_WRITE_CYCLES \
    ((`NVM_INTERNAL_WRITE_NS + `NVM_CLOCK_PERIOD_NS - 1) / `NVM_CLOCK_PERIOD_NS)
`define NVM_BULK_ERASE_CYCLES \
    ((`NVM_BULK_ERASE_NS + `NVM_CLOCK_PERIOD_NS - 1) / `NVM_CLOCK_PERIOD_NS)
`define NVM_ROW_ERASE_CYCLES \
    ((`NVM_ROW_ERASE_NS + `NVM_CLOCK_PERIOD_NS - 1) / `NVM_CLOCK_PERIOD_NS)

`endif

// ### verilog/nvm_prog_pkg.sv
/*
 * Types shared by the serial programming command interpreter.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package nvm_prog_pkg;

    typedef enum logic [1:0] {
        PH_COMMAND,
        PH_LOAD_ADDR,
        PH_LOAD_DATA,
        PH_READ
    } phase_e;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_WRITE_INT,
        OP_WRITE_EXT,
        OP_WRITE_END,
        OP_ERASE_ROW,
        OP_ERASE_BULK
    } nvm_op_e;

    typedef struct packed {
        nvm_op_e     op;
        logic [15:0] addr;
        logic        eraseFlash;
        logic        eraseConfig;
        logic        eraseIds;
    } nvm_cmd_s;

endpackage

// ### verilog/prog_pin_sync.sv
/*
 * Two-stage synchroniser for the programming pins.
 * Assumes pins are asynchronous to clock; reset is synchronous active high.
 */
`timescale 1ns/100ps
`default_nettype none

module prog_pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pins,
    output logic      [WIDTH-1:0] synced
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_s;

    sync_s st;
    sync_s next_st;

    always_comb begin
        next_st.first  = pins;
        next_st.second = st.first;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign synced = st.second;

endmodule

`default_nettype wire

// ### verilog/nvm_serial_program_commands.sv
/*
 * Device-side serial programming command interpreter: 8-bit commands and
 * 24-bit payloads on a programmer-driven clock pin, address counter, row
 * data latches and strobed erase/write requests to the memory array.
 * Assumes the memory answers readData for readAddress on the same clock,
 * and that the programmer clock is far slower than clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "nvm_prog_map.svh"

module nvm_serial_program_commands #(
    parameter int ROW_WORDS = 32,
    parameter int WORD_BITS = 14
) (
    input  wire logic                                clock,
    input  wire logic                                reset,
    input  wire logic                                progClockPin,
    input  wire logic                                progDataIn,
    output logic                                     progDataOut,
    output logic                                     progDataOe,
    input  wire logic                                codeProtect_n,
    input  wire logic [WORD_BITS-1:0]                readData,
    output logic      [15:0]                         readAddress,
    output logic      [ROW_WORDS-1:0][WORD_BITS-1:0] latchWords,
    output nvm_prog_pkg::nvm_cmd_s                   nvmCmd,
    output logic                                     nvmStrobe,
    output logic                                     busy
);

    localparam int IDX = $clog2(ROW_WORDS);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if (ROW_WORDS < 2 || ROW_WORDS > 32 || (ROW_WORDS & (ROW_WORDS - 1)) != 0) begin : g_bad_row
        $error("ROW_WORDS must be a power of two from 2 to 32");
    end
    if (WORD_BITS < 8 || WORD_BITS > 16) begin : g_bad_word
        $error("WORD_BITS must lie between 8 and 16");
    end

    typedef struct packed {
        nvm_prog_pkg::phase_e                 phase;
        logic [4:0]                           bitCount;
        logic [23:0]                          shift;
        logic [7:0]                           cmd;
        logic [15:0]                          pc;
        logic                                 clkPrev;
        logic [ROW_WORDS-1:0][WORD_BITS-1:0]  latches;
        logic                                 dataOut;
        logic                                 dataOe;
        nvm_prog_pkg::nvm_cmd_s               nvmCmd;
        logic                                 nvmStrobe;
        logic                                 busy;
        logic                                 extWrite;
        logic                                 timedWrite;
        logic [11:0]                          timer;
    } state_s;

    state_s st;
    state_s next_st;

    logic [1:0]           synced;
    logic                 clkNow;
    logic                 dataNow;
    logic                 fall;
    logic                 rise;
    logic [7:0]           cmdByte;
    logic                 cmdDone;
    logic [23:0]          payload;
    logic                 payloadEnd;
    logic                 readStart;
    logic                 isConfig;
    logic                 protectedPc;
    logic [WORD_BITS-1:0] readWord;
    logic [15:0]          rowBase;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // The device only ever listens on the clock pin: there is no driver for it.
    prog_pin_sync #(
        .WIDTH (2)
    ) u_sync (
        .clock  (clock),
        .reset  (reset),
        .pins   ({progClockPin, progDataIn}),
        .synced (synced)
    );

    assign clkNow  = synced[1];
    assign dataNow = synced[0];

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_st     = st;
        rise        = clkNow & ~st.clkPrev;
        fall        = ~clkNow & st.clkPrev;
        cmdByte     = {st.shift[6:0], dataNow};
        cmdDone     = fall && st.phase == nvm_prog_pkg::PH_COMMAND && st.bitCount == 5'd7;
        payload     = {st.shift[22:0], dataNow};
        payloadEnd  = fall && st.phase != nvm_prog_pkg::PH_COMMAND
                      && st.bitCount == 5'(`NVM_PAYLOAD_BITS - 1);
        readStart   = fall && st.phase == nvm_prog_pkg::PH_READ && st.bitCount == 5'd0;
        isConfig    = st.pc >= `NVM_CFG_FIRST && st.pc <= `NVM_CFG_LAST;
        protectedPc = !codeProtect_n && st.pc <= `NVM_FLASH_LAST;
        readWord    = protectedPc ? '0 : readData;
        rowBase     = st.pc & ~16'(ROW_WORDS - 1);

        next_st.clkPrev   = clkNow;
        next_st.nvmStrobe = 1'b0;

        // Self-timed operations finish here; the programmer is trusted to wait.
        if (st.timer != 12'h000) begin
            next_st.timer = st.timer - 12'h001;
            if (st.timer == 12'h001) begin
                // An external write still in progress keeps busy up
                next_st.busy       = st.extWrite;
                next_st.timedWrite = 1'b0;
                if (st.timedWrite) begin
                    next_st.latches = '1;
                end
            end
        end

        if (fall && st.phase == nvm_prog_pkg::PH_COMMAND) begin
            next_st.shift    = {16'h0000, cmdByte};
            next_st.bitCount = st.bitCount + 5'd1;
            if (cmdDone) begin
                next_st.bitCount      = 5'd0;
                next_st.cmd           = cmdByte;
                next_st.nvmCmd        = '0;
                next_st.nvmCmd.op     = nvm_prog_pkg::OP_NONE;
                next_st.nvmCmd.addr   = rowBase;
                case (cmdByte)
                    `NVM_CMD_LOAD_ADDR: begin
                        next_st.phase = nvm_prog_pkg::PH_LOAD_ADDR;
                    end
                    `NVM_CMD_LOAD_DATA, `NVM_CMD_LOAD_DATA_INC: begin
                        next_st.phase = nvm_prog_pkg::PH_LOAD_DATA;
                    end
                    `NVM_CMD_READ_DATA, `NVM_CMD_READ_DATA_INC: begin
                        next_st.phase = nvm_prog_pkg::PH_READ;
                    end
                    `NVM_CMD_INC_ADDR: begin
                        next_st.pc = st.pc + 16'h0001;
                    end
                    `NVM_CMD_BEGIN_INT: begin
                        next_st.nvmCmd.op  = nvm_prog_pkg::OP_WRITE_INT;
                        next_st.nvmStrobe  = 1'b1;
                        next_st.busy       = 1'b1;
                        next_st.timedWrite = 1'b1;
                        next_st.timer      = 12'(`NVM_INTERNAL_WRITE_CYCLES);
                    end
                    `NVM_CMD_BEGIN_EXT: begin
                        // Configuration words only change under internal timing.
                        if (!isConfig) begin
                            next_st.nvmCmd.op = nvm_prog_pkg::OP_WRITE_EXT;
                            next_st.nvmStrobe = 1'b1;
                            next_st.busy      = 1'b1;
                            next_st.extWrite  = 1'b1;
                        end
                    end
                    `NVM_CMD_END_EXT: begin
                        if (st.extWrite) begin
                            next_st.nvmCmd.op = nvm_prog_pkg::OP_WRITE_END;
                            next_st.nvmStrobe = 1'b1;
                            next_st.busy      = 1'b0;
                            next_st.extWrite  = 1'b0;
                            next_st.latches   = '1;
                        end
                    end
                    `NVM_CMD_BULK_ERASE: begin
                        next_st.nvmCmd.op   = nvm_prog_pkg::OP_ERASE_BULK;
                        next_st.nvmCmd.addr = st.pc;
                        // Scope ignores the protect bit: this is how it is lifted.
                        if (st.pc <= `NVM_FLASH_LAST) begin
                            next_st.nvmCmd.eraseFlash  = 1'b1;
                            next_st.nvmCmd.eraseConfig = 1'b1;
                        end else if (st.pc <= `NVM_IDCFG_LAST || st.pc > `NVM_NOP_LAST) begin
                            next_st.nvmCmd.eraseFlash  = 1'b1;
                            next_st.nvmCmd.eraseConfig = 1'b1;
                            next_st.nvmCmd.eraseIds    = 1'b1;
                        end else if (st.pc <= `NVM_FLASHONLY_LAST) begin
                            next_st.nvmCmd.eraseFlash  = 1'b1;
                        end
                        if (!st.busy && (st.pc <= `NVM_FLASHONLY_LAST
                                         || st.pc > `NVM_NOP_LAST)) begin
                            next_st.nvmStrobe = 1'b1;
                            next_st.busy      = 1'b1;
                            next_st.timer     = 12'(`NVM_BULK_ERASE_CYCLES);
                        end
                    end
                    `NVM_CMD_ROW_ERASE: begin
                        next_st.nvmCmd.op = nvm_prog_pkg::OP_ERASE_ROW;
                        if (st.pc >= `NVM_ID_FIRST && st.pc <= `NVM_ID_LAST) begin
                            next_st.nvmCmd.eraseIds = 1'b1;
                        end else begin
                            next_st.nvmCmd.eraseFlash = 1'b1;
                        end
                        if (!protectedPc) begin
                            next_st.nvmStrobe = 1'b1;
                            next_st.busy      = 1'b1;
                            next_st.timer     = 12'(`NVM_ROW_ERASE_CYCLES);
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end else if (fall) begin
            next_st.bitCount = st.bitCount + 5'd1;
            if (st.phase == nvm_prog_pkg::PH_READ) begin
                if (readStart) begin
                    // Pad bits after the first go out as zero ahead of the word, and the low zero bit after it.
                    next_st.shift   = 24'({readWord, 1'b0});
                    next_st.dataOe  = 1'b1;
                    next_st.dataOut = 1'b0;
                end
            end else begin
                next_st.shift = payload;
            end
            if (payloadEnd) begin
                next_st.bitCount = 5'd0;
                next_st.phase    = nvm_prog_pkg::PH_COMMAND;
                next_st.shift    = '0;
                case (st.phase)
                    nvm_prog_pkg::PH_LOAD_ADDR: begin
                        next_st.pc = payload[16:1];
                    end
                    nvm_prog_pkg::PH_LOAD_DATA: begin
                        next_st.latches[st.pc[IDX-1:0]] = payload[WORD_BITS:1];
                        next_st.pc = st.pc + 16'(st.cmd[`NVM_CMD_INC_BIT]);
                    end
                    default: begin
                        next_st.dataOe  = 1'b0;
                        next_st.dataOut = 1'b0;
                        next_st.pc = st.pc + 16'(st.cmd[`NVM_CMD_INC_BIT]);
                    end
                endcase
            end
        end else if (rise && st.phase == nvm_prog_pkg::PH_READ && st.bitCount != 5'd0) begin
            // New bit on each rising edge after the first so it is settled at the sampling edge.
            next_st.shift   = {st.shift[22:0], 1'b0};
            next_st.dataOut = st.shift[22];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st         <= '0;
            st.latches <= '1;
            st.phase   <= nvm_prog_pkg::PH_COMMAND;
        end else begin
            st <= next_st;
        end
    end

    assign progDataOut = st.dataOut;
    assign progDataOe  = st.dataOe;
    assign readAddress = st.pc;
    assign latchWords  = st.latches;
    assign nvmCmd      = st.nvmCmd;
    assign nvmStrobe   = st.nvmStrobe;
    assign busy        = st.busy;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence s_cmd(logic [7:0] code);
        cmdDone && cmdByte == code;
    endsequence

    sequence s_busy_hold;
        st.busy [*8];
    endsequence

    a_incr_addr: assert property (s_cmd(`NVM_CMD_INC_ADDR) |=> st.pc == $past(st.pc) + 16'h0001)
        else $error("increment command did not add one");
    a_internal_write: assert property (s_cmd(`NVM_CMD_BEGIN_INT)
        |=> nvmStrobe && nvmCmd.op == nvm_prog_pkg::OP_WRITE_INT ##1 s_busy_hold)
        else $error("internal write not started or not held busy");
    a_latch_ones: assert property (s_cmd(`NVM_CMD_END_EXT) && st.extWrite |=> st.latches == '1)
        else $error("latches not reset after write");
    a_ext_config: assert property (s_cmd(`NVM_CMD_BEGIN_EXT) && isConfig |=> !nvmStrobe)
        else $error("external write issued to configuration word");
    a_end_nop: assert property (s_cmd(`NVM_CMD_END_EXT) && !st.extWrite |=> !nvmStrobe)
        else $error("end command acted without external write");
    a_read_drive: assert property (readStart |=> progDataOe && !progDataOut)
        else $error("read payload did not drive the pin");
    a_read_release: assert property (payloadEnd && st.phase == nvm_prog_pkg::PH_READ
        |=> !progDataOe)
        else $error("pin not released after 24th edge");
    a_read_protect: assert property (readStart && protectedPc |=> st.shift == 24'h000000)
        else $error("protected read returned data");
    a_bulk_busy: assert property (s_cmd(`NVM_CMD_BULK_ERASE) && st.busy |=> !nvmStrobe)
        else $error("bulk erase accepted while busy");
    a_row_protect: assert property (s_cmd(`NVM_CMD_ROW_ERASE) && protectedPc |=> !nvmStrobe)
        else $error("row erase accepted under protection");
    a_load_incr: assert property (payloadEnd && st.phase == nvm_prog_pkg::PH_LOAD_DATA
        && st.cmd[`NVM_CMD_INC_BIT] |=> st.pc == $past(st.pc) + 16'h0001)
        else $error("load with increment did not advance address");
    a_write_done: assert property (st.timedWrite && st.timer == 12'h001
        |=> st.latches == '1)
        else $error("latches not reset after internal write");
    a_bulk_nop: assert property (s_cmd(`NVM_CMD_BULK_ERASE)
        && st.pc > `NVM_FLASHONLY_LAST && st.pc <= `NVM_NOP_LAST |=> !nvmStrobe)
        else $error("bulk erase acted in the empty region");
    a_addr_load: assert property (payloadEnd
        && st.phase == nvm_prog_pkg::PH_LOAD_ADDR |=> st.pc == $past(payload[16:1]))
        else $error("address load did not take the payload");
    a_latch_load: assert property (payloadEnd
        && st.phase == nvm_prog_pkg::PH_LOAD_DATA
        |=> st.latches[$past(st.pc[IDX-1:0])] == $past(payload[WORD_BITS:1]))
        else $error("load data did not fill the addressed latch");

endmodule

`default_nettype wire

// ### tb/prog_host_model.sv
/*
 * Programmer stand-in: makes every serial clock pulse, drives the data pin
 * and releases it for read payloads.
 * Assumes the bench system clock; a pin half period is four clocks.
 */
`timescale 1ns/100ps
`default_nettype none

module prog_host_model #(
    parameter int GAP = 8
) (
    input  wire logic clock,
    input  wire logic progDataOut,
    input  wire logic progDataOe,
    output var logic  progClockPin,
    output logic      progDataIn
);
    logic hostOe = 1'b1;
    logic hostBit = 1'b0;
    logic junk = 1'b0;
    int   oeLow = 0;

    initial progClockPin = 1'b0;
    // A released line must not look like a held last value
    always @(posedge clock) junk <= ~junk;
    assign progDataIn = progDataOe ? progDataOut : (hostOe ? hostBit : junk);

    task automatic xfer(input int n, input logic [23:0] v, input logic drv,
                        output logic [23:0] r);
        int i;
        r = 24'h000000;
        hostOe = drv;
        for (i = n - 1; i >= 0; i--) begin
            hostBit = v[i];
            progClockPin = 1'b1;
            repeat (4) @(posedge clock);
            #1;
            r = {r[22:0], progDataIn};
            if (!drv && i < 23 && progDataOe !== 1'b1) oeLow++;
            progClockPin = 1'b0;
            repeat (4) @(posedge clock);
            #1;
        end
        hostOe = 1'b1;
        repeat (GAP) @(posedge clock);
        #1;
    endtask
endmodule

`default_nettype wire

// ### tb/tb_top.sv
/*
 * Self-checking bench for the serial programming command interpreter.
 * Assumes the package, the design and the programmer model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic                   clock = 1'b0;
    logic                   reset = 1'b1;
    logic                   codeProtect_n = 1'b1;
    logic                   progClockPin, progDataIn, progDataOut, progDataOe;
    logic                   nvmStrobe, busy;
    logic [15:0]            readAddress, a;
    logic [13:0]            readData, w;
    logic [31:0][13:0]      latchWords;
    nvm_prog_pkg::nvm_cmd_s nvmCmd;
    logic [21:0]            got;
    logic [23:0]            r;
    logic [43:0]            notes[$];
    int                     num_errors = 0;
    int                     checks_done = 0;
    int                     seed = 32'h0BCA;
    logic [15:0]            ba [5] = '{16'h1234, 16'h8000, 16'h80FE, 16'h9000, 16'hF000};
    logic [3:0]             bf [5] = '{4'hE, 4'hF, 4'hC, 4'h0, 4'hF};
    logic [15:0]            ra [3] = '{16'h0045, 16'h8002, 16'h0045};

    always #25 clock = ~clock;
    // Memory stand-in: a fixed pattern of the address
    assign readData = readAddress[13:0] ^ 14'h15A3;

    nvm_serial_program_commands dut (.clock(clock), .reset(reset),
        .progClockPin(progClockPin), .progDataIn(progDataIn), .progDataOut(progDataOut),
        .progDataOe(progDataOe), .codeProtect_n(codeProtect_n), .readData(readData),
        .readAddress(readAddress), .latchWords(latchWords), .nvmCmd(nvmCmd),
        .nvmStrobe(nvmStrobe), .busy(busy));
    prog_host_model host (.clock(clock), .progDataOut(progDataOut),
        .progDataOe(progDataOe), .progClockPin(progClockPin), .progDataIn(progDataIn));

    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        host.xfer(8, {16'h0000, c}, 1'b1, r);
    endtask
    task automatic setPc(input logic [15:0] v);
        cmd(8'h80);
        host.xfer(24, {7'h00, v, 1'b0}, 1'b1, r);
    endtask
    task automatic loadWord(input logic [7:0] c, input logic [13:0] v);
        cmd(c);
        host.xfer(24, {9'h000, v, 1'b0}, 1'b1, r);
    endtask
    task automatic note(input nvm_prog_pkg::nvm_op_e op, input logic [15:0] v,
                        input logic [2:0] f, input logic [21:0] m);
        notes.push_back({m, op, v, f});
    endtask
    task automatic waitIdle;
        int i;
        for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clock);
        #1;
        chk(busy === 1'b0, "busy never cleared");
    endtask
    task automatic wrap_up;
        $display("errors %0d, checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Every strobe must match the oldest pending note; masked fields are free
    always @(negedge clock) begin
        if (!reset && nvmStrobe === 1'b1) begin
            got = nvmCmd;
            if (notes.size() == 0) begin
                chk(1'b0, "strobe with nothing pending");
            end else begin
                chk(((got ^ notes[0][21:0]) & notes[0][43:22]) === 22'h0, "command fields");
                void'(notes.pop_front());
            end
        end
    end

    initial begin
        #2000000;
        num_errors++;
        $display("unexpected at %0t: watchdog", $time);
        wrap_up;
    end

    initial begin
        repeat (10) @(posedge clock);
        #1;
        reset = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        chk({busy, progDataOe, readAddress} === 18'h0 && latchWords === '1, "reset");
        for (int k = 0; k < 2; k++) begin
            a = k ? 16'hFFFF : 16'($random(seed));
            setPc(a);
            chk(readAddress === a, "address load");
            cmd(8'hF8);
            chk(readAddress === a + 16'h0001, "increment");
        end
        a = {1'b0, 15'($random(seed))};
        w = 14'($random(seed));
        setPc(a);
        loadWord(8'h02, w);
        chk(latchWords[a[4:0]] === w, "latch load");
        chk(readAddress === a + 16'h0001, "step after load");
        loadWord(8'h00, ~w);
        chk(latchWords[a[4:0] + 5'h01] === ~w, "latch select");
        chk(latchWords[a[4:0] + 5'h02] === '1 && readAddress === a + 16'h0001, "one latch");
        note(nvm_prog_pkg::OP_WRITE_INT, (a + 16'h0001) & 16'hFFE0, 3'h0, 22'h3FFFF8);
        cmd(8'hE0);
        chk(busy === 1'b1 && latchWords[a[4:0]] === w, "write in progress");
        waitIdle;
        chk(latchWords === '1, "latches after write");
        for (int k = 0; k < 4; k++) begin
            a = k[0] ? (k[1] ? 16'h8001 : 16'h8007) : {1'b0, 15'($random(seed))};
            codeProtect_n = ~k[1];
            setPc(a);
            cmd(k[0] ? 8'hFC : 8'hFE);
            host.xfer(24, 24'h000000, 1'b0, r);
            chk(r[14:1] === ((k[1] && !a[15]) ? 14'h0 : a[13:0] ^ 14'h15A3), "read");
            chk(readAddress === a + 16'(!k[0]), "step after read");
            chk(progDataOe === 1'b0 && host.oeLow == 0, "pin direction");
        end
        codeProtect_n = 1'b1;
        setPc(16'h0240);
        loadWord(8'h00, w);
        note(nvm_prog_pkg::OP_WRITE_EXT, 16'h0240, 3'h0, 22'h3FFFF8);
        cmd(8'hC0);
        chk(busy === 1'b1, "external write running");
        note(nvm_prog_pkg::OP_WRITE_END, 16'h0000, 3'h0, 22'h380000);
        cmd(8'h82);
        waitIdle;
        cmd(8'h82);
        setPc(16'h8008);
        loadWord(8'h00, w);
        cmd(8'hC0);
        waitIdle;
        for (int k = 0; k < 5; k++) begin
            codeProtect_n = k[0];
            setPc(ba[k]);
            if (bf[k][3]) note(nvm_prog_pkg::OP_ERASE_BULK, ba[k], bf[k][2:0], 22'h3FFFFF);
            cmd(8'h18);
            waitIdle;
        end
        setPc(16'h0000);
        note(nvm_prog_pkg::OP_WRITE_INT, 16'h0000, 3'h0, 22'h3FFFF8);
        cmd(8'hE0);
        cmd(8'h18);
        waitIdle;
        for (int k = 0; k < 3; k++) begin
            codeProtect_n = k[1];
            setPc(ra[k]);
            if (k > 0) note(nvm_prog_pkg::OP_ERASE_ROW, ra[k] & 16'hFFE0,
                            k == 1 ? 3'h1 : 3'h4, 22'h3FFFFF);
            cmd(8'hF0);
            waitIdle;
        end
        repeat (20) @(posedge clock);
        chk(notes.size() == 0, "strobe never came");
        wrap_up;
    end
endmodule

`default_nettype wire
